// file: rtl/psc_defines.vh
// Constants for the supply setpoint and control register bank.
// Included by the register bank and its two-wire serial slave.
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Byte offsets on the serial bus
`define PSC_OFS_STATUS 8'h6f
`define PSC_OFS_VSET_LO 8'h70
`define PSC_OFS_VSET_HI 8'h71
`define PSC_OFS_ISET_LO 8'h72
`define PSC_OFS_ISET_HI 8'h73
`define PSC_OFS_CONTROL 8'h7c

// Reset values
`define PSC_RST_STATUS 8'h12
`define PSC_RST_CONTROL 8'h00
`define PSC_RST_SETPOINT 16'h0000

// Status fields
`define PSC_ST_REMOTE 7
`define PSC_ST_ON 4
`define PSC_ST_SW_INHIBIT 1
`define PSC_ST_PIN_INHIBIT 0

// Control fields
`define PSC_CT_REMOTE 7
`define PSC_CT_ERROR 3
`define PSC_CT_UPDATE 2
`define PSC_CT_POWER 0

// Default limits and device address
`define PSC_VLIMIT_DEF 16'hffff
`define PSC_ILIMIT_DEF 16'hffff
`define PSC_DEV_ADDR 7'h50

`endif

// file: rtl/psc_serial_slave.v
// Two-wire serial slave: device address, byte pointer, auto-incrementing reads and writes.
// Assumes scl and sda come from pins and are slow against clock_in; sda is open drain.
`timescale 1ns/10ps
`include "psc_defines.vh"

module psc_serial_slave #(
  parameter [6:0] DEV_ADDR = `PSC_DEV_ADDR
) (
  input wire clock_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_out,
  output wire [7:0] rd_addr_out,
  input wire [7:0] rd_data_in,
  output reg wr_out,
  output reg [7:0] wr_addr_out,
  output reg [7:0] wr_data_out
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_DEV = 3'd1;
  localparam [2:0] S_PTR = 3'd2;
  localparam [2:0] S_WR = 3'd3;
  localparam [2:0] S_RD = 3'd4;
  localparam [2:0] S_AW = 3'd5;
  localparam [2:0] S_ACK = 3'd6;
  localparam [2:0] S_MACK = 3'd7;

  reg scl_s1_q, scl_s2_q, scl_s3_q;
  reg sda_s1_q, sda_s2_q, sda_s3_q;
  reg [2:0] state_q, next_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire start_c = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  wire stop_c = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
  wire [7:0] byte_c = {sh_q[6:0], sda_s2_q};

  assign rd_addr_out = ptr_q;

  always @(posedge clock_in) begin
    if (rst_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= S_IDLE;
      next_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_oe_out <= 1'b0;
      wr_out <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
    end else begin
      wr_out <= 1'b0;
      if (start_c) begin
        state_q <= S_DEV;
        cnt_q <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_c) begin
        state_q <= S_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          S_DEV, S_PTR, S_WR: begin
            sh_q <= byte_c;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              state_q <= S_AW;
              if (state_q == S_DEV) begin
                // Foreign address: stay silent until the next start
                if (byte_c[7:1] != DEV_ADDR) begin
                  state_q <= S_IDLE;
                end
                next_q <= byte_c[0] ? S_RD : S_PTR;
              end else if (state_q == S_PTR) begin
                ptr_q <= byte_c;
                next_q <= S_WR;
              end else begin
                wr_out <= 1'b1;
                wr_addr_out <= ptr_q;
                wr_data_out <= byte_c;
                ptr_q <= ptr_q + 8'h01;
                next_q <= S_WR;
              end
            end
          end
          S_MACK: begin
            if (sda_s2_q) begin
              state_q <= S_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          S_AW: begin
            sda_oe_out <= 1'b1;
            state_q <= S_ACK;
          end
          S_ACK, S_MACK: begin
            sda_oe_out <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= next_q;
            if (next_q == S_RD) begin
              sda_oe_out <= ~rd_data_in[7];
              sh_q <= {rd_data_in[6:0], 1'b0};
              cnt_q <= 4'h1;
              ptr_q <= ptr_q + 8'h01;
            end
          end
          S_RD: begin
            if (cnt_q == 4'h8) begin
              sda_oe_out <= 1'b0;
              state_q <= S_MACK;
            end else begin
              sda_oe_out <= ~sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// file: rtl/psc_setpoint_regs.v
// Supply setpoint and control register bank behind a two-wire serial slave.
// Assumes control pins are asynchronous levels, high meaning they hold the output off.
`timescale 1ns/10ps
`include "psc_defines.vh"

module psc_setpoint_regs #(
  parameter [6:0] DEV_ADDR = `PSC_DEV_ADDR,
  parameter [15:0] VOLT_LIMIT = `PSC_VLIMIT_DEF,
  parameter [15:0] CURR_LIMIT = `PSC_ILIMIT_DEF
) (
  input wire clock_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output wire sda_oe_out,
  input wire analog_voltage_program_input_in,
  input wire analog_current_program_input_in,
  input wire output_inhibit_input_in,
  output reg [15:0] voltage_active_out,
  output reg [15:0] current_active_out,
  output reg output_on_out
);
  // Reset images; control bits are picked out of CTRL_RST by field position, the others load whole
  localparam [7:0] CTRL_RST = `PSC_RST_CONTROL;
  localparam [7:0] STATUS_RST = `PSC_RST_STATUS;
  localparam [15:0] SETPOINT_RST = `PSC_RST_SETPOINT;
  localparam integer NUM_PINS = 3;

  wire [7:0] rd_addr;
  wire [7:0] rd_data;
  wire wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire ctrl_wr;
  wire [NUM_PINS-1:0] pin_raw;
  wire [NUM_PINS-1:0] pin_sync;
  wire pin_off;
  wire limits_ok;
  wire [7:0] control_rd;

  reg [15:0] vbuf_q;
  reg [15:0] vbuf_d;
  reg [15:0] ibuf_q;
  reg [15:0] ibuf_d;
  reg remote_q;
  reg remote_d;
  reg power_q;
  reg power_d;
  reg update_q;
  reg update_d;
  reg error_q;
  reg error_d;
  reg [15:0] vact_d;
  reg [15:0] iact_d;
  reg output_on_d;
  reg [7:0] status_q;
  reg [7:0] status_d;

  // Serial slave; its sda enable already comes from a flop
  psc_serial_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .wr_out(wr_stb),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );

  // Inclusive limit: a value equal to the limit is still accepted
  function within_limit;
    input [15:0] value;
    input [15:0] limit;
    begin
      within_limit = (value <= limit);
    end
  endfunction

  // Setpoints read back the buffered value, as last written
  function [7:0] read_mux;
    input [7:0] addr;
    begin
      case (addr)
        `PSC_OFS_STATUS: read_mux = status_q;
        `PSC_OFS_VSET_LO: read_mux = vbuf_q[7:0];
        `PSC_OFS_VSET_HI: read_mux = vbuf_q[15:8];
        `PSC_OFS_ISET_LO: read_mux = ibuf_q[7:0];
        `PSC_OFS_ISET_HI: read_mux = ibuf_q[15:8];
        `PSC_OFS_CONTROL: read_mux = control_rd;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // Reserved control bits read zero; bit 3 is hardware owned
  assign control_rd = {remote_q, 3'b000, error_q, update_q, 1'b0, power_q};
  assign rd_data = read_mux(rd_addr);
  assign ctrl_wr = wr_stb && (wr_addr == `PSC_OFS_CONTROL);

  // Pins are asynchronous: two flops each before any logic reads them
  assign pin_raw = {output_inhibit_input_in, analog_current_program_input_in, analog_voltage_program_input_in};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin_sync
      reg s1_q;
      reg s2_q;
      always @(posedge clock_in) begin
        if (rst_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
      assign pin_sync[gi] = s2_q;
    end
  endgenerate

  // In local mode (remote bit clear), any one pin high holds the output off
  assign pin_off = |pin_sync;
  assign limits_ok = within_limit(vbuf_q, VOLT_LIMIT) & within_limit(ibuf_q, CURR_LIMIT);

  // Holding buffers; the active setting never follows them directly
  always @* begin
    vbuf_d = vbuf_q;
    ibuf_d = ibuf_q;
    if (wr_stb) begin
      case (wr_addr)
        `PSC_OFS_VSET_LO: vbuf_d[7:0] = wr_data;
        `PSC_OFS_VSET_HI: vbuf_d[15:8] = wr_data;
        `PSC_OFS_ISET_LO: ibuf_d[7:0] = wr_data;
        `PSC_OFS_ISET_HI: ibuf_d[15:8] = wr_data;
        default: begin
        end
      endcase
    end
  end

  // Control byte and the checked update
  always @* begin
    remote_d = remote_q;
    power_d = power_q;
    update_d = update_q;
    error_d = error_q;
    vact_d = voltage_active_out;
    iact_d = current_active_out;
    if (update_q) begin
      // Check takes one cycle; host polls bit 2 to see it done
      update_d = 1'b0;
      if (limits_ok) begin
        error_d = 1'b0;
        vact_d = vbuf_q;
        iact_d = ibuf_q;
      end else begin
        // Rejected: the previous active setting stays
        error_d = 1'b1;
      end
    end
    if (ctrl_wr) begin
      remote_d = wr_data[`PSC_CT_REMOTE];
      power_d = wr_data[`PSC_CT_POWER];
      // A new request wins over the self clear of the previous one
      if (wr_data[`PSC_CT_UPDATE]) begin
        update_d = 1'b1;
      end
    end
  end

  // Output state and live status; status bit 4 lags the output by a clock
  always @* begin
    output_on_d = remote_q ? power_q : ~pin_off;
    status_d = 8'h00;
    status_d[`PSC_ST_REMOTE] = remote_q;
    status_d[`PSC_ST_ON] = output_on_out;
    status_d[`PSC_ST_SW_INHIBIT] = remote_q & ~power_q;
    status_d[`PSC_ST_PIN_INHIBIT] = ~remote_q & pin_off;
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      vbuf_q <= SETPOINT_RST;
      ibuf_q <= SETPOINT_RST;
      remote_q <= CTRL_RST[`PSC_CT_REMOTE];
      power_q <= CTRL_RST[`PSC_CT_POWER];
      update_q <= CTRL_RST[`PSC_CT_UPDATE];
      error_q <= CTRL_RST[`PSC_CT_ERROR];
      voltage_active_out <= SETPOINT_RST;
      current_active_out <= SETPOINT_RST;
      output_on_out <= 1'b0;
      status_q <= STATUS_RST;
    end else begin
      vbuf_q <= vbuf_d;
      ibuf_q <= ibuf_d;
      remote_q <= remote_d;
      power_q <= power_d;
      update_q <= update_d;
      error_q <= error_d;
      voltage_active_out <= vact_d;
      current_active_out <= iact_d;
      output_on_out <= output_on_d;
      status_q <= status_d;
    end
  end

  // Open drain: the line is only ever pulled low
  always @(posedge clock_in) begin
    sda_out <= 1'b0;
  end
endmodule

// file: test/psc_regs_props.sv
// Port checker for the setpoint register bank.
// Assumes one clock domain and the bench host's slow serial phases.
`timescale 1ns/10ps
module psc_regs_props #(
  parameter [15:0] VOLT_LIMIT = 16'hffff,
  parameter [15:0] CURR_LIMIT = 16'hffff
) (
  input wire clock_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe_out,
  input wire analog_voltage_program_input_in,
  input wire analog_current_program_input_in,
  input wire output_inhibit_input_in,
  input wire [15:0] voltage_active_out,
  input wire [15:0] current_active_out,
  input wire output_on_out
);
  wire pin_off = analog_voltage_program_input_in | analog_current_program_input_in | output_inhibit_input_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_reset;
    disable iff (1'b0) rst_in |=> voltage_active_out == 16'h0000 && current_active_out == 16'h0000 && !output_on_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_vlim;
    voltage_active_out <= VOLT_LIMIT;
  endproperty
  a_vlim: assert property (p_vlim) else $error("voltage over limit");
  property p_ilim;
    current_active_out <= CURR_LIMIT;
  endproperty
  a_ilim: assert property (p_ilim) else $error("current over limit");
  // Updates land only right after a serial data bit
  property p_vhold;
    $changed(voltage_active_out) |-> $past(scl_in, 2);
  endproperty
  a_vhold: assert property (p_vhold) else $error("voltage moved off update");
  property p_ihold;
    $changed(current_active_out) |-> $past(scl_in, 2);
  endproperty
  a_ihold: assert property (p_ihold) else $error("current moved off update");
  property p_ack;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_ack: assert property (p_ack) else $error("data changed with clock high");
  property p_on;
    $rose(output_on_out) |-> $past(scl_in, 2) || !pin_off;
  endproperty
  a_on: assert property (p_on) else $error("output on without cause");
  property p_off;
    $fell(output_on_out) |-> $past(scl_in, 2) || pin_off;
  endproperty
  a_off: assert property (p_off) else $error("output off without cause");
endmodule
bind psc_setpoint_regs psc_regs_props #(.VOLT_LIMIT(VOLT_LIMIT), .CURR_LIMIT(CURR_LIMIT)) i_psc_regs_props (
  .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_out(sda_oe_out),
  .analog_voltage_program_input_in(analog_voltage_program_input_in),
  .analog_current_program_input_in(analog_current_program_input_in),
  .output_inhibit_input_in(output_inhibit_input_in), .voltage_active_out(voltage_active_out),
  .current_active_out(current_active_out), .output_on_out(output_on_out));

// file: test/psc_host_model.sv
// Serial bus host: byte writes and pointer reads.
// Assumes sda is pulled up outside; phases are 10 clocks.
`timescale 1ns/10ps
`include "psc_defines.vh"
module psc_host_model (
  input wire clock_in,
  input wire sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task hold;
    begin
      repeat (10) @(posedge clock_in);
    end
  endtask
  // Start or repeated start: sda falls while scl is high
  task start_cond;
    begin
      sda_low_out <= 1'b0;
      hold;
      scl_out <= 1'b1;
      hold;
      sda_low_out <= 1'b1;
      hold;
      scl_out <= 1'b0;
      hold;
    end
  endtask
  // Stop: sda rises while scl is high; both lines end released
  task stop_cond;
    begin
      sda_low_out <= 1'b1;
      hold;
      scl_out <= 1'b1;
      hold;
      sda_low_out <= 1'b0;
      hold;
    end
  endtask
  // Ninth bit always released: ack read, or nack sent
  task xfer(input [7:0] d, output [7:0] q);
    reg [8:0] v;
    integer i;
    begin
      v = {d, 1'b1};
      for (i = 8; i >= 0; i = i - 1) begin
        sda_low_out <= !v[i];
        hold;
        scl_out <= 1'b1;
        hold;
        v[i] = sda_in;
        scl_out <= 1'b0;
        hold;
      end
      q = v[8:1];
    end
  endtask
  task write_reg(input [7:0] ofs, input [7:0] data);
    reg [7:0] q;
    begin
      start_cond;
      xfer({`PSC_DEV_ADDR, 1'b0}, q);
      xfer(ofs, q);
      xfer(data, q);
      stop_cond;
    end
  endtask
  task read_reg(input [7:0] ofs, output [7:0] data);
    reg [7:0] q;
    begin
      start_cond;
      xfer({`PSC_DEV_ADDR, 1'b0}, q);
      xfer(ofs, q);
      start_cond;
      xfer({`PSC_DEV_ADDR, 1'b1}, q);
      xfer(8'hff, data);
      stop_cond;
    end
  endtask
endmodule

// file: test/psc_setpoint_regs_bench.sv
// Bench for the setpoint register bank via the serial host model.
// Assumes open-drain sda with a pull-up; limits set low to reach rejection.
`timescale 1ns/10ps
module psc_setpoint_regs_bench;
  reg clock_in = 1'b0;
  reg rst_in = 1'b1;
  reg [2:0] pins = 3'h0;
  wire scl, sda, sda_oe, host_low, on, sdo;
  wire [15:0] vact, iact;
  reg [7:0] rd;
  integer err_count = 0;
  integer n_checks = 0;
  integer k;
  always #25 clock_in = ~clock_in;
  assign sda = !(host_low || sda_oe);
  psc_host_model i_psc_host_model (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  psc_setpoint_regs #(.VOLT_LIMIT(16'h1000), .CURR_LIMIT(16'h4000)) i_psc_setpoint_regs (
    .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe_out(sda_oe),
    .analog_voltage_program_input_in(pins[0]), .analog_current_program_input_in(pins[1]),
    .output_inhibit_input_in(pins[2]), .voltage_active_out(vact), .current_active_out(iact), .output_on_out(on));
  task chk(input [31:0] name, input [15:0] exp, input [15:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task rchk(input [7:0] ofs, input [7:0] exp);
    begin
      i_psc_host_model.read_reg(ofs, rd);
      chk("reg", {8'h00, exp}, {8'h00, rd});
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (80000) @(posedge clock_in);
    err_count = err_count + 1;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    chk("on", 16'h1, {15'h0, on});
    chk("sdo", 16'h0, {15'h0, sdo});
    rchk(8'h7c, 8'h00);
    rchk(8'h6f, 8'h10);
    rchk(8'h70, 8'h00);
    for (k = 0; k < 3; k = k + 1) begin
      pins <= 3'h1 << k;
      rchk(8'h6f, 8'h01);
      chk("on", 16'h0, {15'h0, on});
    end
    pins <= 3'h0;
    i_psc_host_model.write_reg(8'h70, 8'h92);
    i_psc_host_model.write_reg(8'h71, 8'h09);
    i_psc_host_model.write_reg(8'h72, 8'hd4);
    i_psc_host_model.write_reg(8'h73, 8'h30);
    chk("vact", 16'h0000, vact);
    rchk(8'h71, 8'h09);
    i_psc_host_model.write_reg(8'h7c, 8'h85);
    chk("vact", 16'h0992, vact);
    chk("iact", 16'h30d4, iact);
    rchk(8'h7c, 8'h81);
    rchk(8'h6f, 8'h90);
    chk("on", 16'h1, {15'h0, on});
    // Pins held high: software mode must ignore them
    pins <= 3'h7;
    i_psc_host_model.write_reg(8'h7c, 8'h84);
    chk("on", 16'h0, {15'h0, on});
    rchk(8'h6f, 8'h82);
    pins <= 3'h0;
    i_psc_host_model.write_reg(8'h71, 8'h20);
    i_psc_host_model.write_reg(8'h7c, 8'hff);
    chk("vact", 16'h0992, vact);
    rchk(8'h7c, 8'h89);
    // Voltage back in range, current one step over its limit
    i_psc_host_model.write_reg(8'h71, 8'h09);
    i_psc_host_model.write_reg(8'h73, 8'h40);
    i_psc_host_model.write_reg(8'h72, 8'h01);
    i_psc_host_model.write_reg(8'h7c, 8'h85);
    chk("iact", 16'h30d4, iact);
    rchk(8'h7c, 8'h89);
    // Exactly at the limit is accepted and clears the error
    i_psc_host_model.write_reg(8'h72, 8'h00);
    i_psc_host_model.write_reg(8'h7c, 8'h85);
    chk("iact", 16'h4000, iact);
    rchk(8'h7c, 8'h81);
    // Status is read only; unmapped offsets read zero
    i_psc_host_model.write_reg(8'h6f, 8'hff);
    rchk(8'h6f, 8'h90);
    rchk(8'h74, 8'h00);
    // Second reset in mid-run: all state back to reset values
    rst_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    chk("vact", 16'h0000, vact);
    chk("iact", 16'h0000, iact);
    chk("on", 16'h1, {15'h0, on});
    rchk(8'h7c, 8'h00);
    rchk(8'h72, 8'h00);
    print_verdict;
  end
endmodule
